// File: common/panel_pkg.sv
// Constants and types for the front-panel trim and bus address controller
package panel_pkg;
    localparam int unsigned CHANNELS = 2;
    localparam logic [7:0] TRIM_MIN = 8'h37;        // 55
    localparam logic [7:0] TRIM_MAX = 8'hFF;        // 255
    localparam logic [7:0] TRIM_MID = 8'h9B;        // Neutral value after calibration
    localparam logic [4:0] ADDR_DEFAULT = 5'h01;
    localparam logic [4:0] ADDR_MAX = 5'h1F;
    localparam logic [4:0] ADDR_DETACH = 5'h1F;
    localparam logic [7:0] LF_BYTE = 8'h0A;
    localparam logic [4:0] TALK_BASE = 5'h00;       // Talk group offset (address bits)
    localparam logic [1:0] LISTEN_GROUP = 2'b01;    // Bits 6:5 of a listen address
    localparam logic [1:0] TALK_GROUP = 2'b10;      // Bits 6:5 of a talk address
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_OFFSET,
        MODE_GAIN,
        MODE_ADDRESS
    } mode_t;
endpackage : panel_pkg

// File: hw/panel_trim_and_bus_address.sv
// Front-panel trim modes, bus address setting and message terminator logic
//
// Function
// - Coupling plus down key enters offset trim and shows offset (55..255).
// - In offset trim, up/down keys step that channel's offset.
// - Repeating the entry key pair leaves either trim mode.
// - Coupling plus up key enters gain trim and shows gain (55..255).
// - In gain trim, up/down keys step that channel's gain.
// - Manual trimming makes the channel's scale lamp flash as uncalibrated.
// - Self-calibration clears manual trims and the uncalibrated flag.
// - First coupling plus second down key enters address mode, shows address.
// - First channel keys change pending address; repeat pair commits it.
// - Bus address is 1 after reset.
// - Bus address is limited to 0 through 31.
// - Address 31 detaches from the bus: no addressing, no transfers.
// - Received line feed with EOI ends an incoming message.
// - Outgoing message ends with line feed sent with EOI asserted.
// - Own talk address under ATN makes talker, own listen makes listener.
`timescale 1ns/1ps
`default_nettype none
module panel_trim_and_bus_address
    import panel_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_coupling_key,
    input wire logic [1:0] i_range_up_key,
    input wire logic [1:0] i_range_down_key,
    input wire logic i_self_cal,
    input wire logic i_blink_tick,
    input wire logic [7:0] i_bus_data,
    input wire logic i_bus_byte_valid,
    input wire logic i_bus_atn,
    input wire logic i_bus_eoi,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    input wire logic i_tx_last,
    output logic [7:0] o_first_indicator,
    output logic [7:0] o_second_indicator,
    output logic [1:0] o_volts_per_div_lamp,
    output logic [1:0] o_millivolts_per_div_lamp,
    output logic [1:0] o_range_is_mv,
    output logic [1:0] o_trim_mode_offset,
    output logic [1:0] o_trim_mode_gain,
    output logic o_address_mode,
    output logic [4:0] o_bus_address,
    output logic [7:0] o_offset0,
    output logic [7:0] o_offset1,
    output logic [7:0] o_gain0,
    output logic [7:0] o_gain1,
    output logic o_talker,
    output logic o_listener,
    output logic o_msg_end,
    output logic [7:0] o_tx_byte,
    output logic o_tx_byte_valid,
    output logic o_tx_eoi,
    output logic o_tx_ready
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0][1:0] cpl_sync;
        logic [1:0][1:0] up_sync;
        logic [1:0][1:0] dn_sync;
        logic [1:0] cpl_q;
        logic [1:0] up_q;
        logic [1:0] dn_q;
        logic [1:0] cal_sync;
        logic cal_q;
        logic [1:0][2:0] mode;
        logic addr_mode;
        logic [1:0][7:0] offset;
        logic [1:0][7:0] gain;
        logic [1:0] uncal;
        logic blink;
        logic [4:0] address;
        logic [4:0] pending;
        logic talker;
        logic listener;
        logic msg_end;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic tx_eoi;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic [7:0] step_trim(input logic [7:0] v,
                                             input logic up, input logic dn);
        step_trim = v;
        if (up && !dn && v != TRIM_MAX) begin
            step_trim = v + 8'h01;
        end else if (dn && !up && v != TRIM_MIN) begin
            step_trim = v - 8'h01;
        end
    endfunction : step_trim

    logic [1:0] cpl;
    logic [1:0] up;
    logic [1:0] dn;
    logic [1:0] cpl_rise;
    logic [1:0] up_rise;
    logic [1:0] dn_rise;
    logic cal_rise;
    logic detached;

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            cpl[c] = st.cpl_sync[c][1];
            up[c] = st.up_sync[c][1];
            dn[c] = st.dn_sync[c][1];
        end
        cpl_rise = cpl & ~st.cpl_q;
        up_rise = up & ~st.up_q;
        dn_rise = dn & ~st.dn_q;
        cal_rise = st.cal_sync[1] & ~st.cal_q;
        detached = (st.address == ADDR_DETACH);
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic chord_addr;
        logic [1:0] chord_off;
        logic [1:0] chord_gain;
        logic [6:0] cmd;
        chord_addr = 1'b0;
        chord_off = 2'b00;
        chord_gain = 2'b00;
        cmd = 7'h00;
        next_st = st;
        for (int c = 0; c < CHANNELS; c++) begin
            next_st.cpl_sync[c] = {st.cpl_sync[c][0], i_coupling_key[c]};
            next_st.up_sync[c] = {st.up_sync[c][0], i_range_up_key[c]};
            next_st.dn_sync[c] = {st.dn_sync[c][0], i_range_down_key[c]};
        end
        next_st.cal_sync = {st.cal_sync[0], i_self_cal};
        next_st.cpl_q = cpl;
        next_st.up_q = up;
        next_st.dn_q = dn;
        next_st.cal_q = st.cal_sync[1];
        if (i_blink_tick) begin
            next_st.blink = ~st.blink;
        end
        // Chord completes when the last of its two keys goes down
        chord_addr = cpl[0] && dn[1] && (cpl_rise[0] || dn_rise[1]);
        for (int c = 0; c < CHANNELS; c++) begin
            chord_off[c] = cpl[c] && dn[c] && (cpl_rise[c] || dn_rise[c]);
            chord_gain[c] = cpl[c] && up[c] && (cpl_rise[c] || up_rise[c]);
        end
        if (st.addr_mode) begin
            next_st.pending = st.pending;
            if (up_rise[0] && st.pending != ADDR_MAX) begin
                next_st.pending = st.pending + 5'h01;
            end else if (dn_rise[0] && !cpl[0] && st.pending != 5'h00) begin
                next_st.pending = st.pending - 5'h01;
            end
            if (chord_addr) begin
                next_st.address = st.pending;
                next_st.addr_mode = 1'b0;
            end
        end else if (chord_addr && st.mode[0] == 3'(MODE_NORMAL)
                     && st.mode[1] == 3'(MODE_NORMAL)) begin
            next_st.addr_mode = 1'b1;
            next_st.pending = st.address;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                case (mode_t'(st.mode[c]))
                    MODE_NORMAL: begin
                        if (chord_off[c]) begin
                            next_st.mode[c] = 3'(MODE_OFFSET);
                        end else if (chord_gain[c]) begin
                            next_st.mode[c] = 3'(MODE_GAIN);
                        end
                    end
                    MODE_OFFSET: begin
                        if (chord_off[c]) begin
                            next_st.mode[c] = 3'(MODE_NORMAL);
                        end else if (!cpl[c]
                                     && (up_rise[c] || dn_rise[c])) begin
                            next_st.offset[c] = step_trim(st.offset[c],
                                up_rise[c], dn_rise[c]);
                            next_st.uncal[c] = 1'b1;
                        end
                    end
                    MODE_GAIN: begin
                        if (chord_gain[c]) begin
                            next_st.mode[c] = 3'(MODE_NORMAL);
                        end else if (!cpl[c]
                                     && (up_rise[c] || dn_rise[c])) begin
                            next_st.gain[c] = step_trim(st.gain[c],
                                up_rise[c], dn_rise[c]);
                            next_st.uncal[c] = 1'b1;
                        end
                    end
                    default: begin
                        next_st.mode[c] = 3'(MODE_NORMAL);
                    end
                endcase
            end
        end
        if (cal_rise) begin
            next_st.offset = {TRIM_MID, TRIM_MID};
            next_st.gain = {TRIM_MID, TRIM_MID};
            next_st.uncal = 2'b00;
        end
        // Bus side: addressing under ATN, terminator detection
        cmd = i_bus_data[6:0];
        next_st.msg_end = 1'b0;
        if (detached) begin
            next_st.talker = 1'b0;
            next_st.listener = 1'b0;
        end else if (i_bus_byte_valid && i_bus_atn) begin
            if (cmd[6:5] == TALK_GROUP) begin
                next_st.talker = (cmd[4:0] == st.address);
            end else if (cmd[6:5] == LISTEN_GROUP
                         && cmd[4:0] == st.address) begin
                next_st.listener = 1'b1;
            end
        end else if (i_bus_byte_valid && st.listener) begin
            next_st.msg_end = (i_bus_data == LF_BYTE) && i_bus_eoi;
        end
        // Transmit only as talker with ATN released
        next_st.tx_valid = 1'b0;
        next_st.tx_eoi = 1'b0;
        if (i_tx_valid && st.talker && !i_bus_atn && !detached) begin
            next_st.tx_valid = 1'b1;
            next_st.tx_byte = i_tx_last ? LF_BYTE : i_tx_data;
            next_st.tx_eoi = i_tx_last;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
            st.offset <= {TRIM_MID, TRIM_MID};
            st.gain <= {TRIM_MID, TRIM_MID};
            st.address <= ADDR_DEFAULT;
            st.pending <= ADDR_DEFAULT;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_comb begin
        o_first_indicator = 8'h00;
        o_second_indicator = 8'h00;
        if (st.addr_mode) begin
            o_first_indicator = {3'b000, st.pending};
        end else begin
            if (st.mode[0] == MODE_OFFSET) o_first_indicator = st.offset[0];
            if (st.mode[0] == MODE_GAIN) o_first_indicator = st.gain[0];
            if (st.mode[1] == MODE_OFFSET) o_second_indicator = st.offset[1];
            if (st.mode[1] == MODE_GAIN) o_second_indicator = st.gain[1];
        end
        for (int c = 0; c < CHANNELS; c++) begin
            o_trim_mode_offset[c] = (st.mode[c] == 3'(MODE_OFFSET));
            o_trim_mode_gain[c] = (st.mode[c] == 3'(MODE_GAIN));
        end
    end

    // Volts/div lamp blinks while uncalibrated; range is held at volts and the mV/div lamp stays off
    assign o_range_is_mv = 2'b00;
    assign o_volts_per_div_lamp = st.uncal & {2{st.blink}};
    assign o_millivolts_per_div_lamp = 2'b00;
    assign o_address_mode = st.addr_mode;
    assign o_bus_address = st.address;
    assign o_offset0 = st.offset[0];
    assign o_offset1 = st.offset[1];
    assign o_gain0 = st.gain[0];
    assign o_gain1 = st.gain[1];
    assign o_talker = st.talker;
    assign o_listener = st.listener;
    assign o_msg_end = st.msg_end;
    assign o_tx_byte = st.tx_byte;
    assign o_tx_byte_valid = st.tx_valid;
    assign o_tx_eoi = st.tx_eoi;
    assign o_tx_ready = st.talker && !i_bus_atn && !detached;

endmodule : panel_trim_and_bus_address
`default_nettype wire

// File: tb/panel_operator.sv
// Keypad operator and bus controller model facing the panel block
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
    input wire logic i_clk,
    output logic [1:0] o_cpl = 2'b00,
    output logic [1:0] o_up = 2'b00,
    output logic [1:0] o_dn = 2'b00,
    output logic [7:0] o_data = 8'h00,
    output logic o_valid = 1'b0,
    output logic o_atn = 1'b0,
    output logic o_eoi = 1'b0
);
    // Coupling key leads so the step key completes the chord
    task automatic press(input logic [1:0] c, u, d);
        o_cpl = c;
        @(negedge i_clk);
        {o_up, o_dn} = {u, d};
        repeat (6) @(negedge i_clk);
        {o_cpl, o_up, o_dn} = 6'h00;
        repeat (6) @(negedge i_clk);
    endtask : press
    // Released data lines show the inverse, never a stale copy
    task automatic send(input logic [7:0] d, input logic a, e);
        {o_data, o_atn, o_eoi, o_valid} = {d, a, e, 1'b1};
        @(negedge i_clk);
        {o_data, o_atn, o_eoi, o_valid} = {~d, 3'b000};
        @(negedge i_clk);
    endtask : send
endmodule : panel_operator
`default_nettype wire

// File: tb/panel_props.sv
// Port checks for the panel trim and bus address block
`timescale 1ns/1ps
`default_nettype none
module panel_props
    import panel_pkg::*;
(
    input wire logic i_core_clk, i_rst_n, i_self_cal, i_bus_byte_valid,
    input wire logic i_bus_atn, i_bus_eoi, i_tx_valid, i_tx_last,
    input wire logic [7:0] i_bus_data, o_offset0, o_tx_byte,
    input wire logic [4:0] o_bus_address,
    input wire logic o_talker, o_listener, o_msg_end,
    input wire logic o_tx_byte_valid, o_tx_eoi, o_tx_ready
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_last_in;
        i_tx_valid && o_tx_ready && i_tx_last;
    endsequence
    sequence s_lf_out;
        o_tx_byte_valid && o_tx_eoi && o_tx_byte == LF_BYTE;
    endsequence
    a_trim_floor: assert property (o_offset0 >= TRIM_MIN)
        else $error("offset below floor");
    a_detach_quiet: assert property (
        (o_bus_address == ADDR_DETACH) [*3] |-> !o_talker && !o_listener)
        else $error("detached yet addressed");
    a_detach_noready: assert property (
        o_bus_address == ADDR_DETACH |-> !o_tx_ready)
        else $error("detached yet ready");
    a_tx_lf_end: assert property (s_last_in |-> ##[1:2] s_lf_out)
        else $error("last byte not sent as lf with eoi");
    a_msg_end_cause: assert property (o_msg_end |-> $past(
        o_listener && i_bus_byte_valid && !i_bus_atn && i_bus_eoi &&
        i_bus_data == LF_BYTE))
        else $error("message end without lf and eoi");
    a_talk_addr: assert property (i_bus_byte_valid && i_bus_atn &&
        i_bus_data[6:5] == TALK_GROUP && i_bus_data[4:0] == o_bus_address &&
        o_bus_address != ADDR_DETACH |=> o_talker) else $error("no talker");
    a_listen_addr: assert property (i_bus_byte_valid && i_bus_atn &&
        i_bus_data[6:5] == LISTEN_GROUP && i_bus_data[4:0] == o_bus_address
        && o_bus_address != ADDR_DETACH |=> o_listener)
        else $error("no listener");
    a_cal_clears: assert property (
        $rose(i_self_cal) |-> ##[3:6] o_offset0 == TRIM_MID)
        else $error("calibration kept trim");
endmodule : panel_props
bind panel_trim_and_bus_address panel_props u_props (.i_core_clk, .i_rst_n,
    .i_self_cal, .i_bus_byte_valid, .i_bus_atn, .i_bus_eoi, .i_tx_valid,
    .i_tx_last, .i_bus_data, .o_offset0, .o_tx_byte, .o_bus_address,
    .o_talker, .o_listener, .o_msg_end, .o_tx_byte_valid, .o_tx_eoi,
    .o_tx_ready);
`default_nettype wire

// File: tb/panel_trim_and_bus_address_tb_top.sv
// Self-checking bench for the panel trim and bus address block
`timescale 1ns/1ps
`default_nettype none
module panel_trim_and_bus_address_tb_top;
    import panel_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cal = 1'b0, tick = 1'b0;
    logic tv = 1'b0, tl = 1'b0, txv, txe, ce, bv, atn, eoi;
    logic am, talk, lis, mend, txr;
    logic [7:0] td = 8'h41, bd, i1, i2, o0, o1, g0, g1, txb, cb;
    logic [1:0] cpl, up, dn, lamp, mvl, mo, mg;
    logic [4:0] addr;
    int error_cnt = 0, n_compared = 0, mcnt = 0, tcnt = 0;
    always #10 clk = ~clk;
    panel_operator op (.i_clk(clk), .o_cpl(cpl), .o_up(up), .o_dn(dn),
        .o_data(bd), .o_valid(bv), .o_atn(atn), .o_eoi(eoi));
    panel_trim_and_bus_address uut (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_coupling_key(cpl), .i_range_up_key(up), .i_range_down_key(dn),
        .i_self_cal(cal), .i_blink_tick(tick), .i_bus_data(bd),
        .i_bus_byte_valid(bv), .i_bus_atn(atn), .i_bus_eoi(eoi),
        .i_tx_data(td), .i_tx_valid(tv), .i_tx_last(tl),
        .o_first_indicator(i1), .o_second_indicator(i2),
        .o_volts_per_div_lamp(lamp), .o_millivolts_per_div_lamp(mvl),
        .o_range_is_mv(), .o_trim_mode_offset(mo), .o_trim_mode_gain(mg),
        .o_address_mode(am), .o_bus_address(addr), .o_offset0(o0),
        .o_offset1(o1), .o_gain0(g0), .o_gain1(g1), .o_talker(talk),
        .o_listener(lis), .o_msg_end(mend), .o_tx_byte(txb),
        .o_tx_byte_valid(txv), .o_tx_eoi(txe), .o_tx_ready(txr));
    // One-cycle pulses, counted at the falling edge where they are settled
    always @(negedge clk) begin
        if (mend === 1'b1) mcnt++;
        if (txv === 1'b1) {tcnt, cb, ce} = {tcnt + 1, txb, txe};
    end
    task automatic chk(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk(addr, ADDR_DEFAULT);
        op.press(2'b01, 2'b00, 2'b01);
        chk({mo, i1}, {2'b01, TRIM_MID});
        repeat (2) op.press(2'b00, 2'b01, 2'b00);
        op.press(2'b00, 2'b00, 2'b01);
        chk({o0, o1}, {TRIM_MID + 8'h01, TRIM_MID});
        op.press(2'b01, 2'b00, 2'b01);
        chk(mo, 2'b00);
        tick = 1'b1;
        @(negedge clk) tick = 1'b0;
        repeat (2) @(negedge clk);
        chk({mvl, lamp}, 4'b0001);
        op.press(2'b10, 2'b10, 2'b00);
        chk({mg, i2}, {2'b10, TRIM_MID});
        op.press(2'b00, 2'b10, 2'b00);
        chk({g1, g0}, {TRIM_MID + 8'h01, TRIM_MID});
        op.press(2'b10, 2'b10, 2'b00);
        chk(mg, 2'b00);
        cal = 1'b1;
        repeat (8) @(negedge clk);
        chk({o0, g1, lamp}, {TRIM_MID, TRIM_MID, 2'b00});
        op.press(2'b01, 2'b00, 2'b01);
        repeat (101) op.press(2'b00, 2'b00, 2'b01);
        chk(o0, TRIM_MIN);
        op.press(2'b01, 2'b00, 2'b01);
        op.press(2'b10, 2'b10, 2'b00);
        repeat (101) op.press(2'b00, 2'b10, 2'b00);
        chk(g1, TRIM_MAX);
        op.press(2'b10, 2'b10, 2'b00);
        op.press(2'b01, 2'b00, 2'b10);
        chk({am, i1}, {1'b1, 3'b000, ADDR_DEFAULT});
        repeat (2) op.press(2'b00, 2'b00, 2'b01);
        chk(i1, 8'h00);
        op.press(2'b01, 2'b00, 2'b10);
        chk({am, addr}, 6'h00);
        op.send({1'b0, LISTEN_GROUP, 5'h00}, 1'b1, 1'b0);
        chk(lis, 1'b1);
        op.send(8'h41, 1'b0, 1'b1);
        op.send(LF_BYTE, 1'b0, 1'b1);
        chk(mcnt, 1);
        op.send({1'b0, TALK_GROUP, 5'h00}, 1'b1, 1'b0);
        chk({talk, txr}, 2'b11);
        tv = 1'b1;
        @(negedge clk) tl = 1'b1;
        @(negedge clk) {tv, tl} = 2'b00;
        repeat (2) @(negedge clk);
        chk({tcnt[7:0], cb, ce}, {8'h02, LF_BYTE, 1'b1});
        op.press(2'b01, 2'b00, 2'b10);
        repeat (33) op.press(2'b00, 2'b01, 2'b00);
        chk(i1, {3'b000, ADDR_MAX});
        op.press(2'b01, 2'b00, 2'b10);
        chk({addr, talk, lis, txr}, {ADDR_DETACH, 3'b000});
        op.send({1'b0, TALK_GROUP, ADDR_DETACH}, 1'b1, 1'b0);
        chk(talk, 1'b0);
        end_of_test();
    end
    initial begin
        #200_000;
        error_cnt++;
        end_of_test();
    end
endmodule : panel_trim_and_bus_address_tb_top
`default_nettype wire
